// ---- rtl/rlc_pkg.sv ----
/*
  Shared constants for the repeat and block-repeat loop control.
  Assumes a 16-bit program address and a 16-bit data address space.
*/
package rlc_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          CNT_W        = 16;
  localparam logic [15:0] RPT_CNT_RST  = 16'h0000;
  localparam logic [15:0] BLK_CNT_RST  = 16'h0000;
  localparam logic [15:0] LOOP_ADR_RST = 16'h0000;
  localparam logic [15:0] MMR_PER_LO   = 16'h0020;
  localparam logic [15:0] MMR_PER_HI   = 16'h004f;

  typedef enum logic [1:0] {
    RLC_IDLE = 2'b01,
    RLC_RUN  = 2'b10
  } rlc_rpt_state_e;
endpackage

// ---- rtl/rlc_loop_ctrl.sv ----
/*
  Loop control between the instruction decoder and the PC sequencer:
  single-instruction repeat, zero-overhead block repeat, interrupt
  masking during repeat, bus-hold answer and the peripheral wait cycle.
  Assumes decoder strobes are one-cycle pulses on MCLK; only the
  bus-hold request comes from a pin and is synchronised here.
*/
module rlc_loop_ctrl (
  input  wire  logic                       MCLK,
  input  wire  logic                       RST,
  input  wire  logic                       CE,
  input  wire  logic                       RPT_DECODE,
  input  wire  logic                       REPEAT_SINGLE_ZEROING_INSTR_DECODE,
  input  wire  logic [rlc_pkg::CNT_W-1:0]  RPT_OPERAND,
  input  wire  logic                       EXEC_DONE,
  input  wire  logic                       BLOCK_REPEAT_INSTR_EXEC,
  input  wire  logic [rlc_pkg::ADDR_W-1:0] BLOCK_REPEAT_INSTR_NEXT_PC,
  input  wire  logic [rlc_pkg::ADDR_W-1:0] BLOCK_REPEAT_INSTR_END_OPERAND,
  input  wire  logic                       BLK_CNT_WR,
  input  wire  logic [rlc_pkg::CNT_W-1:0]  BLK_CNT_WDATA,
  input  wire  logic                       BLK_FLAG_WR,
  input  wire  logic                       BLK_FLAG_WDATA,
  input  wire  logic                       PC_UPDATE,
  input  wire  logic [rlc_pkg::ADDR_W-1:0] PC_VALUE,
  input  wire  logic                       DATA_ACCESS,
  input  wire  logic [rlc_pkg::ADDR_W-1:0] DATA_ADDR,
  input  wire  logic                       BUS_HOLD_REQ_N,
  output logic                             BUS_HOLD_ACK_N,
  output logic                             INT_MASK,
  output logic                             REPEAT_ACTIVE,
  output logic [rlc_pkg::CNT_W-1:0]        REPEAT_COUNT,
  output logic                             CLR_ACC_PROD,
  output logic                             PIPE_ONE_CYCLE,
  output logic                             BLOCK_ACTIVE,
  output logic [rlc_pkg::CNT_W-1:0]        BLOCK_COUNT,
  output logic [rlc_pkg::ADDR_W-1:0]       LOOP_START,
  output logic [rlc_pkg::ADDR_W-1:0]       LOOP_END,
  output logic                             PC_RELOAD,
  output logic [rlc_pkg::ADDR_W-1:0]       PC_RELOAD_ADDR,
  output logic                             EXTRA_WAIT
);
  import rlc_pkg::*;

  // single repeat group
  rlc_rpt_state_e      state_q;
  rlc_rpt_state_e      state_d;
  logic [CNT_W-1:0]    rpt_cnt_q;
  logic [CNT_W-1:0]    rpt_cnt_d;
  logic                first_q;
  logic                first_d;
  logic                clr_q;
  logic                clr_d;
  logic                pipe_q;
  logic                pipe_d;

  always_comb
  begin
    state_d   = state_q;
    rpt_cnt_d = rpt_cnt_q;
    first_d   = first_q;
    clr_d     = 1'b0;
    unique case (state_q)
      RLC_IDLE:
      begin
        if (RPT_DECODE || REPEAT_SINGLE_ZEROING_INSTR_DECODE)
        begin
          rpt_cnt_d = RPT_OPERAND;
          state_d   = RLC_RUN;
          first_d   = 1'b1;
          clr_d     = REPEAT_SINGLE_ZEROING_INSTR_DECODE;
        end
      end
      RLC_RUN:
      begin
        if (EXEC_DONE)
        begin
          first_d = 1'b0;
          // counter at zero means this was the last of N+1 passes
          if (rpt_cnt_q == '0)
            state_d = RLC_IDLE;
          else
            rpt_cnt_d = rpt_cnt_q - 1'b1;
        end
      end
    endcase
    // after the first pass the pipeline is full, one result per cycle
    pipe_d = (state_d == RLC_RUN) && !first_d;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_q   <= RLC_IDLE;
      rpt_cnt_q <= RPT_CNT_RST;
      first_q   <= 1'b0;
      clr_q     <= 1'b0;
      pipe_q    <= 1'b0;
    end
    else if (CE)
    begin
      state_q   <= state_d;
      rpt_cnt_q <= rpt_cnt_d;
      first_q   <= first_d;
      clr_q     <= clr_d;
      pipe_q    <= pipe_d;
    end
  end

  // block repeat group; nothing here looks at branches or calls,
  // so leaving and re-entering the loop keeps its state
  logic [ADDR_W-1:0]   start_q;
  logic [ADDR_W-1:0]   start_d;
  logic [ADDR_W-1:0]   end_q;
  logic [ADDR_W-1:0]   end_d;
  logic [CNT_W-1:0]    blk_cnt_q;
  logic [CNT_W-1:0]    blk_cnt_d;
  logic                flag_q;
  logic                flag_d;
  logic                reload_q;
  logic                reload_d;

  always_comb
  begin
    start_d   = start_q;
    end_d     = end_q;
    blk_cnt_d = blk_cnt_q;
    flag_d    = flag_q;
    reload_d  = 1'b0;
    // a cleared flag suppresses the compare, so the pass ends normally
    if (PC_UPDATE && flag_q && PC_VALUE == end_q)
    begin
      if (blk_cnt_q != '0)
      begin
        blk_cnt_d = blk_cnt_q - 1'b1;
        reload_d  = 1'b1;
      end
      else
        flag_d = 1'b0;
    end
    if (BLK_CNT_WR)
      blk_cnt_d = BLK_CNT_WDATA;
    if (BLK_FLAG_WR)
      flag_d = BLK_FLAG_WDATA;
    if (BLOCK_REPEAT_INSTR_EXEC)
    begin
      start_d = BLOCK_REPEAT_INSTR_NEXT_PC;
      end_d   = BLOCK_REPEAT_INSTR_END_OPERAND;
      flag_d  = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      start_q   <= LOOP_ADR_RST;
      end_q     <= LOOP_ADR_RST;
      blk_cnt_q <= BLK_CNT_RST;
      flag_q    <= 1'b0;
      reload_q  <= 1'b0;
    end
    else if (CE)
    begin
      start_q   <= start_d;
      end_q     <= end_d;
      blk_cnt_q <= blk_cnt_d;
      flag_q    <= flag_d;
      reload_q  <= reload_d;
    end
  end

  // hold pin synchroniser, mask and wait group
  logic                hold_s1_q;
  logic                hold_s2_q;
  logic                ack_n_q;
  logic                ack_n_d;
  logic                mask_q;
  logic                mask_d;
  logic                wait_q;
  logic                wait_d;

  always_comb
  begin
    // hold is answered whatever the repeat state
    ack_n_d = ~hold_s2_q;
    // mask follows the repeat state; it drops when the repeat ends or on the asynchronous clear below
    mask_d  = (state_d == RLC_RUN);
    wait_d  = DATA_ACCESS && DATA_ADDR >= MMR_PER_LO
              && DATA_ADDR <= MMR_PER_HI;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
      ack_n_q   <= 1'b1;
      mask_q    <= 1'b0;
      wait_q    <= 1'b0;
    end
    else if (CE)
    begin
      hold_s1_q <= ~BUS_HOLD_REQ_N;
      hold_s2_q <= hold_s1_q;
      ack_n_q   <= ack_n_d;
      mask_q    <= mask_d;
      wait_q    <= wait_d;
    end
  end

  assign BUS_HOLD_ACK_N = ack_n_q;
  assign INT_MASK       = mask_q;
  assign REPEAT_ACTIVE  = (state_q == RLC_RUN);
  assign REPEAT_COUNT   = rpt_cnt_q;
  assign CLR_ACC_PROD   = clr_q;
  assign PIPE_ONE_CYCLE = pipe_q;
  assign BLOCK_ACTIVE   = flag_q;
  assign BLOCK_COUNT    = blk_cnt_q;
  assign LOOP_START     = start_q;
  assign LOOP_END       = end_q;
  assign PC_RELOAD      = reload_q;
  assign PC_RELOAD_ADDR = start_q;
  assign EXTRA_WAIT     = wait_q;

  property p_rpt_load;
    @(posedge MCLK) disable iff (RST)
    CE && state_q == RLC_IDLE && (RPT_DECODE || REPEAT_SINGLE_ZEROING_INSTR_DECODE)
    |=> REPEAT_ACTIVE && REPEAT_COUNT == $past(RPT_OPERAND);
  endproperty
  a_rpt_load: assert property (p_rpt_load)
    else $error("repeat counter not loaded from operand");

  property p_rpt_dec;
    @(posedge MCLK) disable iff (RST)
    CE && REPEAT_ACTIVE && EXEC_DONE && REPEAT_COUNT != '0
    |=> REPEAT_ACTIVE && REPEAT_COUNT == $past(REPEAT_COUNT) - 16'h0001;
  endproperty
  a_rpt_dec: assert property (p_rpt_dec)
    else $error("repeat counter did not step down by one");

  property p_rpt_end;
    @(posedge MCLK) disable iff (RST)
    CE && REPEAT_ACTIVE && EXEC_DONE && REPEAT_COUNT == '0
    |=> !REPEAT_ACTIVE && !INT_MASK;
  endproperty
  a_rpt_end: assert property (p_rpt_end)
    else $error("repeat did not end after zero pass");

  property p_zero_clr;
    @(posedge MCLK) disable iff (RST)
    CE && state_q == RLC_IDLE && REPEAT_SINGLE_ZEROING_INSTR_DECODE |=> CLR_ACC_PROD && first_q;
  endproperty
  a_zero_clr: assert property (p_zero_clr)
    else $error("zeroing repeat did not clear accumulator");

  property p_mask;
    @(posedge MCLK) disable iff (RST)
    REPEAT_ACTIVE && !$past(REPEAT_ACTIVE) |-> INT_MASK;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupts not masked at repeat start");

  property p_hold;
    @(posedge MCLK) disable iff (RST)
    CE && REPEAT_ACTIVE && hold_s2_q |=> !BUS_HOLD_ACK_N;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold not acknowledged during repeat");

  property p_block_repeat_instr;
    @(posedge MCLK) disable iff (RST)
    CE && BLOCK_REPEAT_INSTR_EXEC |=> BLOCK_ACTIVE && LOOP_START == $past(BLOCK_REPEAT_INSTR_NEXT_PC)
      && LOOP_END == $past(BLOCK_REPEAT_INSTR_END_OPERAND);
  endproperty
  a_block_repeat_instr: assert property (p_block_repeat_instr)
    else $error("block repeat registers not loaded");

  property p_reload;
    @(posedge MCLK) disable iff (RST)
    CE && !BLOCK_REPEAT_INSTR_EXEC && !BLK_CNT_WR && PC_UPDATE && BLOCK_ACTIVE
      && PC_VALUE == LOOP_END && BLOCK_COUNT != '0
    |=> PC_RELOAD && PC_RELOAD_ADDR == $past(LOOP_START)
      && BLOCK_COUNT == $past(BLOCK_COUNT) - 16'h0001;
  endproperty
  a_reload: assert property (p_reload)
    else $error("loop end match did not reload start");

  property p_exit;
    @(posedge MCLK) disable iff (RST)
    CE && !BLOCK_REPEAT_INSTR_EXEC && !BLK_FLAG_WR && PC_UPDATE && BLOCK_ACTIVE
      && PC_VALUE == LOOP_END && BLOCK_COUNT == '0
    |=> !BLOCK_ACTIVE && !PC_RELOAD;
  endproperty
  a_exit: assert property (p_exit)
    else $error("loop did not exit at zero count");

  property p_wait;
    @(posedge MCLK) disable iff (RST)
    CE && DATA_ACCESS && DATA_ADDR inside {[16'h0020:16'h004f]}
    |=> EXTRA_WAIT;
  endproperty
  a_wait: assert property (p_wait)
    else $error("peripheral access got no extra cycle");

  c_repeat_single_zeroing_instr: cover property (@(posedge MCLK) disable iff (RST)
    CLR_ACC_PROD ##[1:20] !REPEAT_ACTIVE);
  c_pipe: cover property (@(posedge MCLK) disable iff (RST)
    PIPE_ONE_CYCLE && !BUS_HOLD_ACK_N);
  c_loop: cover property (@(posedge MCLK) disable iff (RST)
    PC_RELOAD ##[1:50] PC_RELOAD);
  c_exit: cover property (@(posedge MCLK) disable iff (RST)
    $fell(BLOCK_ACTIVE));
endmodule

// ---- tb/rlc_seq_model.sv ----
/*
  sequencer model: answers a running single repeat with executions.
  assumes MCLK and RST from the bench; drives on the falling edge.
*/
module rlc_seq_model (
  input  wire logic MCLK,
  input  wire logic RST,
  input  wire logic REPEAT_ACTIVE,
  input  wire logic SLOW,
  output logic      EXEC_DONE,
  output int        N_EXEC
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph;
  // slow mode gives a gap every other cycle, like multicycle fetches
  always @(negedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      EXEC_DONE <= 1'b0;
      ph        <= 1'b0;
      N_EXEC    <= 0;
    end
    else
    begin
      ph        <= ~ph;
      EXEC_DONE <= REPEAT_ACTIVE & (~SLOW | ph);
      if (REPEAT_ACTIVE & (~SLOW | ph))
        N_EXEC <= N_EXEC + 1;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
/*
  bench for the loop control: repeats, block loops, wait cycle.
  assumes rlc_pkg and the sequencer model are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rlc_pkg::*;
  logic mclk = 0, rst = 1, hold_n = 1, slow = 0, ce = 1;
  logic [31:0] r;
  logic [15:0] wadr [6] = '{16'h001f, 16'h0020, 16'h004f, 16'h0050,
                            16'h0000, 16'h0030};
  logic repeat_single_instr = 0, repeat_single_zeroing_instr = 0, done, block_repeat_instr = 0, cwr = 0, fwr = 0, fdat = 0;
  logic pcu = 0, dacc = 0;
  logic [15:0] opnd = 0, npc = 0, endo = 0, cdat = 0, pcv = 0, dadr = 0;
  logic ack_n, imask, ract, clr, pipe, bact, reld, xw;
  logic [15:0] rcnt, bcnt, lst, lend, radr;
  int error_cnt = 0, samples_checked = 0, nexec, tick = 0;
  logic [31:0] seed = 32'hadd1af97;
  always #5 mclk = ~mclk;
  rlc_loop_ctrl uut (.MCLK(mclk), .RST(rst), .CE(ce),
    .RPT_DECODE(repeat_single_instr), .REPEAT_SINGLE_ZEROING_INSTR_DECODE(repeat_single_zeroing_instr), .RPT_OPERAND(opnd),
    .EXEC_DONE(done), .BLOCK_REPEAT_INSTR_EXEC(block_repeat_instr), .BLOCK_REPEAT_INSTR_NEXT_PC(npc),
    .BLOCK_REPEAT_INSTR_END_OPERAND(endo), .BLK_CNT_WR(cwr), .BLK_CNT_WDATA(cdat),
    .BLK_FLAG_WR(fwr), .BLK_FLAG_WDATA(fdat), .PC_UPDATE(pcu),
    .PC_VALUE(pcv), .DATA_ACCESS(dacc), .DATA_ADDR(dadr),
    .BUS_HOLD_REQ_N(hold_n), .BUS_HOLD_ACK_N(ack_n), .INT_MASK(imask),
    .REPEAT_ACTIVE(ract), .REPEAT_COUNT(rcnt), .CLR_ACC_PROD(clr),
    .PIPE_ONE_CYCLE(pipe), .BLOCK_ACTIVE(bact), .BLOCK_COUNT(bcnt),
    .LOOP_START(lst), .LOOP_END(lend), .PC_RELOAD(reld),
    .PC_RELOAD_ADDR(radr), .EXTRA_WAIT(xw));
  rlc_seq_model seq (.MCLK(mclk), .RST(rst), .REPEAT_ACTIVE(ract),
    .SLOW(slow), .EXEC_DONE(done), .N_EXEC(nexec));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // n+1 executions must follow; one pass per count value from n down to zero
  task automatic rep(input logic [15:0] n, input logic z, input logic s);
    int e0, cyc, ims, pp;
    slow = s;
    e0 = nexec;
    cyc = 0;
    ims = 0;
    pp = 0;
    opnd = n;
    repeat_single_instr = ~z;
    repeat_single_zeroing_instr = z;
    @(negedge mclk);
    repeat_single_instr = 0;
    repeat_single_zeroing_instr = 0;
    chk(rcnt, n);
    chk(clr, z);
    while (ract === 1'b1 && cyc < 70000)
    begin
      ims += (imask === 1'b1);
      pp += (pipe === 1'b1);
      if (cyc == 5)
        chk(ack_n, hold_n);
      cyc++;
      @(negedge mclk);
    end
    chk(nexec - e0, n + 1);
    chk(ims, cyc);
    chk(imask, 0);
    if (!s)
      chk(pp, n);
    $display("repeat test n=%0d done", n);
  endtask
  task automatic blk(input logic [15:0] c, input logic [15:0] s,
                     input logic early);
    int rl;
    logic [15:0] e;
    rl = 0;
    e = early ? s + 16'h0004 : s + 16'h0002;
    cwr = 1;
    cdat = c;
    @(negedge mclk);
    cwr = 0;
    block_repeat_instr = 1;
    npc = s;
    endo = e;
    @(negedge mclk);
    block_repeat_instr = 0;
    chk({lst, lend}, {s, e});
    chk(bact, 1);
    pcu = 1;
    pcv = e + 16'h0100;
    @(negedge mclk);
    chk({bact, bcnt}, {1'b1, c});
    for (int p = 0; p <= (early ? 0 : c); p++)
      for (logic [15:0] a = s; a <= e; a++)
      begin
        pcv = a;
        fwr = early && a == s;
        @(negedge mclk);
        rl += (reld === 1'b1);
        if (reld === 1'b1)
          chk(radr, s);
      end
    pcu = 0;
    chk(rl, early ? 0 : c);
    chk({bact, bcnt}, {1'b0, early ? c : 16'h0});
    chk(lend, e);
    $display("block test c=%0d done", c);
  endtask
  always @(posedge mclk)
  begin
    tick++;
    if (tick == 90000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 0;
    chk({rcnt, ack_n}, {16'h0, 1'b1});
    rep(0, 0, 0);
    rep(0, 1, 0);
    hold_n = 0;
    rep(10, 0, 0);
    hold_n = 1;
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      rep(r[15:0] & 16'h001f, r[8], r[9]);
    end
    rep(16'hffff, 1, 0);
    blk(0, 16'h0200, 0);
    blk(5, 16'h0400, 1);
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      blk(r[15:0] & 16'h0003, r[31:16] & 16'h7ff0, 1'b0);
    end
    // freeze mid repeat; with CE low only reset ends the repeat
    slow = 0;
    opnd = 16'h0100;
    repeat_single_instr = 1;
    @(negedge mclk);
    repeat_single_instr = 0;
    repeat (10) @(negedge mclk);
    ce = 0;
    repeat (4) @(negedge mclk);
    chk({ract, imask, rcnt}, {2'b11, 16'h00f6});
    rst = 1;
    @(negedge mclk);
    chk({ract, imask, rcnt}, {2'b00, RPT_CNT_RST});
    ce = 1;
    rst = 0;
    rep(3, 0, 0);
    $display("freeze and reset test done");
    // back to back accesses at both edges of the range, then one idle
    for (int k = 0; k < 6; k++)
    begin
      dacc = (k != 5);
      dadr = wadr[k];
      @(negedge mclk);
      chk(xw, dacc && dadr >= MMR_PER_LO && dadr <= MMR_PER_HI);
    end
    dacc = 0;
    $display("wait test done");
    close_out();
  end
endmodule
